// [rtl/ccs_top.v]
// Chain clock synchronisation and control: roles, cable clock, tick and time counters
`timescale 1ns/100ps
`include "ccs_defines.vh"
module ccs_top (
  input  wire        CLK,
  input  wire        SRST,
  input  wire        CHAIN_IN_PRESENT,
  input  wire        CHAIN_OUT_PRESENT,
  input  wire        MASTER_SEL,
  input  wire        CHAIN_CLK_IN,
  input  wire        CHAIN_ZERO_IN,
  input  wire        PPS_IN,
  input  wire        PPS_POL,
  input  wire        SYNC_REQ,
  input  wire        CABLE_EN_SET,
  input  wire        CABLE_EN_CLR,
  input  wire        CTL_WR,
  input  wire        CTL_SEL,
  input  wire        CTL_LOCAL_EN,
  input  wire        CTL_CABLE_RESET_EN,
  input  wire        CTL_KEEP,
  input  wire        CTL_CONNECT,
  input  wire        LOAD_STB,
  input  wire        LOAD_SEL,
  input  wire [63:0] LOAD_VAL,
  output reg         CHAIN_CLK_OUT,
  output reg         CHAIN_ZERO_OUT,
  output reg  [1:0]  ROLE,
  output reg  [1:0]  CABLE_STATE,
  output reg         SYNC_DONE,
  output reg         SYNC_ERR,
  output reg  [1:0]  CABLE_SYNC,
  output reg  [1:0]  CABLE_RESET_EN,
  output reg  [1:0]  LOCAL_EN,
  output reg  [1:0]  KEEP_WHEN_OFF,
  output reg  [1:0]  CONNECTED,
  output reg  [63:0] TICK_COUNT,
  output reg  [63:0] TIME_COUNT,
  output reg  [63:0] PPS_CAPTURE
);
  localparam DIV_W  = 8;
  localparam MISS_W = 8;

  reg [2:0] clk_sync_q;
  reg [2:0] zero_sync_q;
  reg [2:0] pps_sync_q;
  reg       cable_en_q;
  reg [DIV_W-1:0] div_q;
  reg [MISS_W-1:0] miss_q;
  reg       zero_pend_q;
  reg       is_master_q;
  reg [1:0] role_q;
  reg [1:0] cab_reset_q;
  reg [1:0] local_en_q;
  reg [1:0] keep_q;
  reg [1:0] conn_q;
  wire [63:0] tick_q;
  wire [63:0] time_q;

  // Chain inputs come from another board's clock domain
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      clk_sync_q  <= 3'h0;
      zero_sync_q <= 3'h0;
      pps_sync_q  <= 3'h0;
    end
    else
    begin
      clk_sync_q  <= {clk_sync_q[1:0], CHAIN_CLK_IN};
      zero_sync_q <= {zero_sync_q[1:0], CHAIN_ZERO_IN};
      pps_sync_q  <= {pps_sync_q[1:0], PPS_IN ^ PPS_POL};
    end
  end

  wire cable_rise = clk_sync_q[1] & ~clk_sync_q[2];
  wire zero_rise  = zero_sync_q[1] & ~zero_sync_q[2];
  wire pps_rise   = pps_sync_q[1] & ~pps_sync_q[2];

  // Master's shared clock divider; edge at wrap, phase half-way for output
  wire div_wrap    = (div_q == (`CCS_TICK_CYC - 1));
  wire local_tick  = div_wrap;
  wire master_step = local_tick & cable_en_q;
  wire chain_step  = is_master_q ? master_step : cable_rise;
  wire missing     = !is_master_q && (miss_q >= `CCS_MISS_CYC);
  wire sync_ok     = SYNC_REQ && (role_q == `CCS_ROLE_MASTER || role_q == `CCS_ROLE_ISO);
  wire chain_zero  = is_master_q ? zero_pend_q : zero_rise;

  // Connected counters step on the chain clock, isolated ones on local ticks
  wire tick_step = conn_q[0] ? chain_step : local_tick;
  wire time_step = conn_q[1] ? chain_step : local_tick;
  wire tick_zero = chain_zero | (sync_ok && role_q == `CCS_ROLE_ISO);

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      div_q         <= {DIV_W{1'b0}};
      miss_q        <= {MISS_W{1'b0}};
      cable_en_q    <= 1'b1;
      zero_pend_q   <= 1'b0;
      is_master_q   <= 1'b0;
      role_q        <= `CCS_ROLE_ISO;
      cab_reset_q   <= 2'h3;
      local_en_q    <= 2'h3;
      keep_q        <= 2'h0;
      conn_q        <= 2'h0;
      CHAIN_CLK_OUT <= 1'b0;
      CHAIN_ZERO_OUT <= 1'b0;
      ROLE          <= `CCS_ROLE_ISO;
      CABLE_STATE   <= `CCS_CAB_ENABLED;
      SYNC_DONE     <= 1'b0;
      SYNC_ERR      <= 1'b0;
      CABLE_SYNC    <= 2'h0;
      CABLE_RESET_EN <= 2'h0;
      LOCAL_EN      <= 2'h0;
      KEEP_WHEN_OFF <= 2'h0;
      CONNECTED     <= 2'h0;
      TICK_COUNT    <= 64'h0000000000000000;
      TIME_COUNT    <= 64'h0000000000000000;
      PPS_CAPTURE   <= 64'h0000000000000000;
    end
    else
    begin
      div_q <= div_wrap ? {DIV_W{1'b0}} : div_q + {{(DIV_W-1){1'b0}}, 1'b1};
      is_master_q <= MASTER_SEL && CHAIN_OUT_PRESENT;
      if (MASTER_SEL && CHAIN_OUT_PRESENT)
        role_q <= `CCS_ROLE_MASTER;
      else if (!CHAIN_IN_PRESENT)
        role_q <= `CCS_ROLE_ISO;
      else if (CHAIN_OUT_PRESENT)
        role_q <= `CCS_ROLE_PASS;
      else
        role_q <= `CCS_ROLE_FINAL;
      ROLE <= role_q;
      if (CABLE_EN_SET)
        cable_en_q <= 1'b1;
      else if (CABLE_EN_CLR)
        cable_en_q <= 1'b0;
      // Cable edge watchdog on slaves
      if (cable_rise || is_master_q)
        miss_q <= {MISS_W{1'b0}};
      else if (!missing)
        miss_q <= miss_q + {{(MISS_W-1){1'b0}}, 1'b1};
      // Master zero pulse waits for the next shared edge so all boards clear together
      if (sync_ok && role_q == `CCS_ROLE_MASTER)
        zero_pend_q <= 1'b1;
      else if (master_step)
        zero_pend_q <= 1'b0;
      SYNC_DONE <= sync_ok;
      SYNC_ERR  <= SYNC_REQ && !sync_ok;
      if (is_master_q)
        CABLE_STATE <= cable_en_q ? `CCS_CAB_ENABLED : `CCS_CAB_DISABLED;
      else if (missing && !clk_sync_q[1])
        CABLE_STATE <= `CCS_CAB_STOPPED;
      else if (missing)
        CABLE_STATE <= `CCS_CAB_MISSING;
      else
        CABLE_STATE <= (conn_q != 2'h0) ? `CCS_CAB_ENABLED : `CCS_CAB_DISABLED;
      if (CTL_WR)
      begin
        local_en_q[CTL_SEL]  <= CTL_LOCAL_EN;
        cab_reset_q[CTL_SEL] <= CTL_CABLE_RESET_EN;
        keep_q[CTL_SEL]      <= CTL_KEEP;
        conn_q[CTL_SEL]      <= CTL_CONNECT;
      end
      // Forward clock: master drives its own, slaves repeat the cable
      CHAIN_CLK_OUT  <= is_master_q ? (cable_en_q && div_q < (`CCS_TICK_CYC / 2)) : clk_sync_q[1];
      CHAIN_ZERO_OUT <= is_master_q ? zero_pend_q : zero_sync_q[1];
      CABLE_SYNC     <= conn_q & {2{!is_master_q && !missing}};
      CABLE_RESET_EN <= cab_reset_q;
      LOCAL_EN       <= local_en_q;
      KEEP_WHEN_OFF  <= keep_q;
      CONNECTED      <= conn_q;
      TICK_COUNT     <= tick_q;
      TIME_COUNT     <= time_q;
      if (pps_rise)
        PPS_CAPTURE <= time_q;
    end
  end

  ccs_counter #(.IS_TIME(0)) u_tick (
    .clk            (CLK),
    .srst           (SRST),
    .step           (tick_step),
    .chain_zero     (tick_zero),
    .connected      (conn_q[0] | (role_q == `CCS_ROLE_ISO)),
    .cable_reset_en (cab_reset_q[0]),
    .local_en       (local_en_q[0]),
    .keep_when_off  (keep_q[0]),
    .load           (1'b0),
    .load_val       (64'h0000000000000000),
    .count_q        (tick_q)
  );

  ccs_counter #(.IS_TIME(1)) u_time (
    .clk            (CLK),
    .srst           (SRST),
    .step           (time_step),
    .chain_zero     (1'b0),
    .connected      (conn_q[1]),
    .cable_reset_en (cab_reset_q[1]),
    .local_en       (local_en_q[1]),
    .keep_when_off  (keep_q[1]),
    .load           (LOAD_STB && LOAD_SEL),
    .load_val       (LOAD_VAL),
    .count_q        (time_q)
  );
endmodule

// [rtl/ccs_defines.vh]
// Constants for the chain clock synchronisation and control block
// Notes on behaviour
// - Chain sync clears every accepting tick counter to zero in the same shared clock cycle.
// - Sync request completes on master or isolated board, refused with error on slave.
// - Device reports its role: master, pass-through slave, final slave or isolated.
// - Cable status: master forwards clock, or slave follows master rather than local ticks.
// - Error flag when the shared chain clock is not reaching slaves.
// - Separate error flag when the shared chain clock is halted low.
// - Per-counter flag set while the counter on a slave is stepped by the master cable clock; always clear on the master.
// - Per-counter flag selects whether chain synchronisation clears the counter; the time counter ignores it and is never cleared by sync.
// - Per-counter local enable; counter advances only while set.
// - Per-counter flag keeps the value instead of clearing while disabled.
// - Each counter isolated or connected; isolated ignores chain clock and chain resets, except the tick counter on an isolated board, which sync clears.
// - Master gates cable clock; connected counters stop, then resume together.
// - Time counters advance in lockstep but keep own values; loads are local.
// - Time counter captured on on-time edge of pulse-per-second input.
// - Tick counter 64 bits, plus one per shared clock cycle of fixed period.
// - Time counter 64 bits: seconds high half, nanoseconds low half.
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_CLK_HZ        50000000
`define CCS_TICK_NS       400
`define CCS_TICK_CYC      ((`CCS_TICK_NS * (`CCS_CLK_HZ / 1000000)) / 1000)
`define CCS_NS_WRAP       32'h3B9ACA00
`define CCS_MISS_CYC      (4 * `CCS_TICK_CYC)
`define CCS_ROLE_MASTER   2'h0
`define CCS_ROLE_PASS     2'h1
`define CCS_ROLE_FINAL    2'h2
`define CCS_ROLE_ISO      2'h3
`define CCS_CAB_ENABLED   2'h0
`define CCS_CAB_DISABLED  2'h1
`define CCS_CAB_MISSING   2'h2
`define CCS_CAB_STOPPED   2'h3
`endif

// [rtl/ccs_counter.v]
// One chain-driven counter: tick counter or seconds/nanoseconds time counter
`timescale 1ns/100ps
`include "ccs_defines.vh"
module ccs_counter #(
  parameter IS_TIME = 0
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        step,
  input  wire        chain_zero,
  input  wire        connected,
  input  wire        cable_reset_en,
  input  wire        local_en,
  input  wire        keep_when_off,
  input  wire        load,
  input  wire [63:0] load_val,
  output reg  [63:0] count_q
);
  reg [63:0] count_d;
  wire [31:0] ns_next = count_q[31:0] + `CCS_TICK_NS;

  always @*
  begin
    count_d = count_q;
    if (load)
      count_d = load_val;
    else if (connected && cable_reset_en && chain_zero)
      count_d = 64'h0000000000000000;
    else if (!local_en)
    begin
      if (!keep_when_off)
        count_d = 64'h0000000000000000;
    end
    else if (step)
    begin
      if (IS_TIME != 0)
      begin
        if (ns_next >= `CCS_NS_WRAP)
        begin
          count_d[31:0]  = ns_next - `CCS_NS_WRAP;
          count_d[63:32] = count_q[63:32] + 32'h00000001;
        end
        else
          count_d[31:0] = ns_next;
      end
      else
        count_d = count_q + 64'h0000000000000001;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
      count_q <= 64'h0000000000000000;
    else
      count_q <= count_d;
  end
endmodule

// [verif/ccs_checker.sv]
// Port-level assertions for the chain clock control block
`timescale 1ns/100ps
module ccs_checker (
  input wire        CLK,
  input wire        SRST,
  input wire        MASTER_SEL,
  input wire        CHAIN_IN_PRESENT,
  input wire        CHAIN_OUT_PRESENT,
  input wire        SYNC_REQ,
  input wire [1:0]  ROLE,
  input wire        SYNC_DONE,
  input wire        SYNC_ERR,
  input wire [1:0]  CABLE_SYNC,
  input wire [1:0]  LOCAL_EN,
  input wire [1:0]  KEEP_WHEN_OFF,
  input wire [1:0]  CONNECTED,
  input wire [63:0] TICK_COUNT,
  input wire [63:0] TIME_COUNT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_tick_off; (!LOCAL_EN[0] && !KEEP_WHEN_OFF[0]) [*4]; endsequence
  sequence s_time_hold; (!LOCAL_EN[1] && KEEP_WHEN_OFF[1]) [*4]; endsequence
  property p_sync_err; SYNC_REQ && (ROLE == 2'h1 || ROLE == 2'h2) |=> SYNC_ERR && !SYNC_DONE; endproperty
  property p_sync_done; SYNC_REQ && (ROLE == 2'h0 || ROLE == 2'h3) |=> SYNC_DONE && !SYNC_ERR; endproperty
  property p_tick_step;
    TICK_COUNT != $past(TICK_COUNT) |-> TICK_COUNT == $past(TICK_COUNT) + 64'h1 || TICK_COUNT == 64'h0;
  endproperty
  property p_ns_range; TIME_COUNT[31:0] < 32'h3B9ACA00; endproperty
  property p_tick_off; s_tick_off |-> TICK_COUNT == 64'h0; endproperty
  property p_keep; s_time_hold |-> $stable(TIME_COUNT); endproperty
  property p_cable_sync; (CONNECTED == 2'h0) [*4] |-> CABLE_SYNC == 2'h0; endproperty
  property p_role_iso; (!MASTER_SEL && !CHAIN_IN_PRESENT && !CHAIN_OUT_PRESENT) [*3] |-> ROLE == 2'h3; endproperty
  a_sync_err: assert property (p_sync_err) else $error("sync on slave not refused");
  a_sync_done: assert property (p_sync_done) else $error("sync on master or isolated not done");
  a_tick_step: assert property (p_tick_step) else $error("tick count moved by other than one");
  a_ns_range: assert property (p_ns_range) else $error("nanoseconds out of range");
  a_tick_off: assert property (p_tick_off) else $error("disabled tick count not cleared");
  a_keep: assert property (p_keep) else $error("kept time count changed");
  a_cable_sync: assert property (p_cable_sync) else $error("isolated counter follows cable");
  a_role_iso: assert property (p_role_iso) else $error("role not isolated");
endmodule

// [verif/ccs_chain_model.sv]
// Upstream board that sources the shared cable clock
`timescale 1ns/100ps
module ccs_chain_model (
  input  wire run,
  input  wire idle_lvl,
  output reg  chain_clk
);
  initial chain_clk = 1'b0;
  // Toggles only while running, otherwise parks at the chosen level
  always
  begin
    #80;
    chain_clk = run ? ~chain_clk : idle_lvl;
  end
endmodule

// [verif/chain_clock_sync_control_tb.sv]
// Self-checking bench for the chain clock control block
`timescale 1ns/100ps
module chain_clock_sync_control_tb;
  reg         clk, srst, in_p, out_p, msel, pps, sreq, cset, cclr, wr, sel, len, keep, conn, ld, run, idle;
  reg  [63:0] lval, exp_t, exp_s;
  reg  [31:0] rs;
  wire        ck_in, ck_out, z_out, done, err;
  wire [1:0]  role, cst, csync, cre, len_q, keep_q, conn_q;
  wire [63:0] tick, tim, cap;
  integer     n_fail, n_compared, i;
  ccs_chain_model peer (.run(run), .idle_lvl(idle), .chain_clk(ck_in));
  ccs_top dut (.CLK(clk), .SRST(srst), .CHAIN_IN_PRESENT(in_p), .CHAIN_OUT_PRESENT(out_p), .MASTER_SEL(msel),
    .CHAIN_CLK_IN(ck_in), .CHAIN_ZERO_IN(1'b0), .PPS_IN(pps), .PPS_POL(1'b0), .SYNC_REQ(sreq),
    .CABLE_EN_SET(cset), .CABLE_EN_CLR(cclr), .CTL_WR(wr), .CTL_SEL(sel), .CTL_LOCAL_EN(len),
    .CTL_CABLE_RESET_EN(1'b1), .CTL_KEEP(keep), .CTL_CONNECT(conn), .LOAD_STB(ld), .LOAD_SEL(1'b1),
    .LOAD_VAL(lval), .CHAIN_CLK_OUT(ck_out), .CHAIN_ZERO_OUT(z_out), .ROLE(role), .CABLE_STATE(cst),
    .SYNC_DONE(done), .SYNC_ERR(err), .CABLE_SYNC(csync), .CABLE_RESET_EN(cre), .LOCAL_EN(len_q),
    .KEEP_WHEN_OFF(keep_q), .CONNECTED(conn_q), .TICK_COUNT(tick), .TIME_COUNT(tim), .PPS_CAPTURE(cap));
  task check(input [63:0] seen, input [63:0] want);
  begin
    n_compared = n_compared + 1;
    if (seen !== want)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  end
  endtask
  task summarize;
  begin
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task ctl(input s, input e, input k, input c);
  begin
    {sel, len, keep, conn, wr} = {s, e, k, c, 1'b1};
    cyc(1);
    wr = 1'b0;
    cyc(4);
  end
  endtask
  task sync(input [1:0] want);
    reg [1:0] got;
  begin
    got = 2'h0;
    sreq = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      cyc(1);
      sreq = 1'b0;
      got = got | {err, done};
    end
    check(got, want);
  end
  endtask
  // Bounded wait for a counter value; running out counts as a mismatch
  task wait_val(input t, input [63:0] v);
  begin
    for (i = 0; i < 100 && (t ? tim : tick) !== v; i = i + 1)
      cyc(1);
    if (i == 100)
    begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {srst, in_p, out_p, msel, pps, sreq, cset, cclr, wr, sel, len, keep, conn, ld, run, idle} = 16'h8000;
    {lval, n_fail, n_compared} = 0;
    rs = 32'h35F7;
    cyc(2);
    srst = 1'b0;
    cyc(3);
    check(role, 2'h3);
    check({len_q, cre, keep_q, conn_q, cst}, 10'h3C1);
    {exp_t, exp_s} = {tick, tim};
    cyc(20);
    check(tick, exp_t + 64'h1);
    check(tim, exp_s + 64'h190);
    sync(2'h1);
    wait_val(1'b0, 64'h0);
    {msel, out_p} = 2'h3;
    cyc(4);
    check(role, 2'h0);
    // Master tick counter must be connected to accept the chain zero
    ctl(1'b0, 1'b1, 1'b0, 1'b1);
    sync(2'h1);
    wait_val(1'b0, 64'h0);
    ctl(1'b1, 1'b1, 1'b0, 1'b1);
    cclr = 1'b1;
    cyc(1);
    cclr = 1'b0;
    cyc(4);
    check(cst, 2'h1);
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    lval = {rs, 32'h3B9AC870};
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cyc(40);
    check(tim, lval);
    cset = 1'b1;
    cyc(1);
    cset = 1'b0;
    wait_val(1'b1, {rs + 32'h1, 32'h0});
    check(cst, 2'h0);
    ctl(1'b1, 1'b0, 1'b1, 1'b1);
    exp_t = tim;
    cyc(30);
    check(tim, exp_t);
    pps = 1'b1;
    cyc(6);
    check(cap, exp_t);
    pps = 1'b0;
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(40);
    check(tick, 64'h0);
    {msel, in_p, out_p} = 3'h3;
    cyc(100);
    check(role, 2'h1);
    check(cst, 2'h3);
    sync(2'h2);
    idle = 1'b1;
    cyc(100);
    check(cst, 2'h2);
    out_p = 1'b0;
    run = 1'b1;
    ctl(1'b0, 1'b1, 1'b1, 1'b1);
    cyc(40);
    check(role, 2'h2);
    check({csync[0], cst}, 3'h4);
    summarize;
  end
endmodule
bind ccs_top ccs_checker u_chk (.CLK(CLK), .SRST(SRST), .MASTER_SEL(MASTER_SEL), .CHAIN_IN_PRESENT(CHAIN_IN_PRESENT),
  .CHAIN_OUT_PRESENT(CHAIN_OUT_PRESENT), .SYNC_REQ(SYNC_REQ), .ROLE(ROLE), .SYNC_DONE(SYNC_DONE),
  .SYNC_ERR(SYNC_ERR), .CABLE_SYNC(CABLE_SYNC), .LOCAL_EN(LOCAL_EN), .KEEP_WHEN_OFF(KEEP_WHEN_OFF),
  .CONNECTED(CONNECTED), .TICK_COUNT(TICK_COUNT), .TIME_COUNT(TIME_COUNT));
